// File: verilog/spi_sec_defs.svh
// offsets, field positions, reset values and timing counts of the serial status port
`ifndef SPI_SEC_DEFS_SVH
`define SPI_SEC_DEFS_SVH

// frame layout
`define FRAME_BITS      5'h10
`define RW_BIT          15
`define IDX_MSB         14
`define IDX_LSB         9
`define PARITY_BIT      8

// register indices
`define IDX_IC_STATUS   6'h00
`define IDX_STATUS_ONE  6'h01
`define IDX_STATUS_TWO  6'h02
`define IDX_CTRL_FIRST  6'h03
`define IDX_CTRL_LAST   6'h08
`define IDX_LAST_VALID  6'h0C

// ic status fields
`define IC_REG_FLT      6
`define IC_SER_FLT      5
`define IC_OVERCURRENT  4
`define IC_SUPPLY_READY 3
`define IC_OVERVOLT     2
`define IC_TEMP         1
`define IC_SUMMARY      0

// second status register fields
`define ST2_PARITY      2
`define ST2_CLK_COUNT   1
`define ST2_BAD_INDEX   0

// reset values
`define STATUS_RESET    8'h00
`define CTRL_RESET      8'h00

// timing
`define CLOCK_MHZ       125
`define CS_GAP_NS       400
`define CS_GAP_CYC      ((`CS_GAP_NS * `CLOCK_MHZ + 999) / 1000)
`define RST_WINDOW_NS   20000
`define RST_WINDOW_CYC  ((`RST_WINDOW_NS * `CLOCK_MHZ) / 1000)

`endif

// File: verilog/spi_sec_pkg.sv
// types shared by the serial status port
`default_nettype none
package spi_sec_pkg;

    // conditions reported by the surrounding driver logic
    typedef struct packed {
        logic       regulator_fault;
        logic       overcurrent;
        logic       supply_ready;
        logic       overvoltage;
        logic       temperature;
        logic [7:0] status_one;
        logic [3:0] status_two_hi;
    } driver_cond_s;

    // sleep pin tracking, gray along awake -> low -> asleep
    typedef enum logic [1:0] {
        SLP_AWAKE  = 2'b00,
        SLP_LOW    = 2'b01,
        SLP_ASLEEP = 2'b11
    } sleep_state_e;

endpackage
`default_nettype wire

// File: verilog/pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // system
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // pins
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: verilog/latch_flag.sv
// sticky error flag, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module latch_flag (
    // system
    input  wire logic clock,
    input  wire logic rst,
    // control
    input  wire logic set,
    input  wire logic clear,
    output logic      flag_reg
);
    logic flag_next;

    // a set in the clearing cycle is kept
    assign flag_next = set | (flag_reg & ~clear);

    always_ff @(posedge clock) begin
        if (rst) begin
            flag_reg <= 1'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule
`default_nettype wire

// File: verilog/spi_secondary_status_port.sv
// serial secondary port with status registers and latched frame errors
`timescale 1ns/1ns
`default_nettype none
`include "spi_sec_defs.svh"
module spi_secondary_status_port
    import spi_sec_pkg::*;
#(
    parameter int RST_WINDOW = `RST_WINDOW_CYC
) (
    // system
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // serial pins
    input  wire logic         sclk_pin,
    input  wire logic         chip_select_low,
    input  wire logic         sdi_pin,
    output logic              sdo_out,
    output logic              sdo_oe,
    // sleep and fault pins
    input  wire logic         sleep_low_pin,
    output logic              error_out_low,
    // driver conditions and error clear command
    input  wire driver_cond_s cond,
    input  wire logic         clear_latched_errors
);
    localparam int LW = $clog2(RST_WINDOW + 1);

    // synchronised pins and delayed copies
    logic [3:0]   pins_s;
    logic         sclk_s;
    logic         cs_s;
    logic         sdi_s;
    logic         sleep_s;
    logic         sclk_d_reg;
    logic         cs_d_reg;

    // frame state
    logic         in_frame_reg;
    logic [4:0]   bit_cnt_reg;
    logic [15:0]  in_shift_reg;
    logic [15:0]  out_shift_reg;
    logic [7:0]   ctrl_mem [`IDX_CTRL_FIRST:`IDX_LAST_VALID];

    // status registers
    logic [7:0]   ic_status_reg;
    logic [7:0]   status_one_reg;
    logic [7:0]   status_two_reg;
    logic [7:0]   ic_status_next;
    logic [7:0]   status_two_next;

    // sleep tracking
    sleep_state_e sleep_state_reg;
    sleep_state_e sleep_state_next;
    logic [LW-1:0] low_cnt_reg;
    logic         pin_clear_reg;

    // decoded terms
    logic         sclk_fall;
    logic         sclk_rise;
    logic         cs_fall;
    logic         cs_rise;
    logic         awake;
    logic         sleep_reset;
    logic         frame_end;
    logic         len_ok;
    logic         parity_ok;
    logic [5:0]   frame_idx;
    logic [5:0]   early_idx;
    logic         idx_ok;
    logic         writable;
    logic         commit;
    logic         read_phase;
    logic [7:0]   read_byte;
    logic         clear_all;
    logic         par_flag;
    logic         clk_flag;
    logic         idx_flag;
    logic         ser_err;
    logic         window_done;

    // pins enter through two flops; reset to idle levels so no false clock edge follows reset
    pin_sync #(
        .WIDTH     (4),
        .RESET_VAL (4'h5)
    ) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({sclk_pin, chip_select_low, sdi_pin, sleep_low_pin}),
        .sync_out (pins_s)
    );

    assign sclk_s  = pins_s[3];
    assign cs_s    = pins_s[2];
    assign sdi_s   = pins_s[1];
    assign sleep_s = pins_s[0];

    // edge detection on synchronised levels
    assign sclk_fall = sclk_d_reg & ~sclk_s;
    assign sclk_rise = ~sclk_d_reg & sclk_s;
    assign cs_fall   = cs_d_reg & ~cs_s;
    assign cs_rise   = ~cs_d_reg & cs_s;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclk_d_reg <= 1'h0;
            cs_d_reg   <= 1'h1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_d_reg   <= cs_s;
        end
    end

    // sleep pin: short low clears errors, long low puts registers to sleep
    assign awake       = (sleep_state_reg != SLP_ASLEEP);
    assign sleep_reset = sys_rst | ~awake;
    assign window_done = (low_cnt_reg == LW'(RST_WINDOW - 1));

    always_comb begin
        sleep_state_next = sleep_state_reg;
        unique case (sleep_state_reg)
            SLP_AWAKE: begin
                if (!sleep_s) sleep_state_next = SLP_LOW;
            end
            SLP_LOW: begin
                if (sleep_s) sleep_state_next = SLP_AWAKE;
                else if (window_done) sleep_state_next = SLP_ASLEEP;
            end
            SLP_ASLEEP: begin
                if (sleep_s) sleep_state_next = SLP_AWAKE;
            end
            default: sleep_state_next = SLP_AWAKE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sleep_state_reg <= SLP_AWAKE;
            low_cnt_reg     <= '0;
            pin_clear_reg   <= 1'h0;
        end else begin
            sleep_state_reg <= sleep_state_next;
            low_cnt_reg     <= (sleep_state_reg == SLP_LOW) ? low_cnt_reg + 1'b1 : '0;
            pin_clear_reg   <= (sleep_state_reg == SLP_LOW) & sleep_s;
        end
    end

    // frame checks at chip select release
    assign frame_end = in_frame_reg & cs_rise;
    assign len_ok    = (bit_cnt_reg == `FRAME_BITS);
    assign parity_ok = ~^in_shift_reg;
    assign frame_idx = in_shift_reg[`IDX_MSB:`IDX_LSB];
    assign early_idx = in_shift_reg[5:0];
    assign idx_ok    = (frame_idx <= `IDX_LAST_VALID);
    assign writable  = ((frame_idx >= `IDX_CTRL_FIRST) && (frame_idx <= `IDX_CTRL_LAST))
                     || (frame_idx == `IDX_LAST_VALID);
    assign commit    = frame_end & len_ok & parity_ok & idx_ok & writable
                     & ~in_shift_reg[`RW_BIT];
    assign read_phase = in_frame_reg & sclk_fall & (bit_cnt_reg == 5'h07);

    // register byte for the second half of the answer
    assign read_byte = (early_idx == `IDX_IC_STATUS)  ? ic_status_reg  :
                       (early_idx == `IDX_STATUS_ONE) ? status_one_reg :
                       (early_idx == `IDX_STATUS_TWO) ? status_two_reg :
                       (early_idx <= `IDX_LAST_VALID) ? ctrl_mem[early_idx] : 8'h00;

    // serial shifting: sample on fall, change on rise, msb first
    always_ff @(posedge clock) begin
        if (sleep_reset) begin
            in_frame_reg  <= 1'h0;
            bit_cnt_reg   <= 5'h00;
            in_shift_reg  <= 16'h0000;
            out_shift_reg <= 16'h0000;
        end else if (cs_fall) begin
            in_frame_reg  <= 1'h1;
            bit_cnt_reg   <= 5'h00;
            out_shift_reg <= {ic_status_reg, 8'h00};
        end else if (cs_rise) begin
            in_frame_reg  <= 1'h0;
        end else if (in_frame_reg && !cs_s) begin
            if (sclk_fall) begin
                in_shift_reg <= {in_shift_reg[14:0], sdi_s};
                if (bit_cnt_reg <= `FRAME_BITS) bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (read_phase) out_shift_reg[14:7] <= read_byte;
            end else if (sclk_rise && (bit_cnt_reg != 5'h00)) begin
                // the first rise presents the status msb loaded at chip select fall
                out_shift_reg <= {out_shift_reg[14:0], 1'h0};
            end
        end
    end

    // control bytes change only on a committed frame, or return to defaults in reset and sleep
    always_ff @(posedge clock) begin
        if (sleep_reset) begin
            for (int i = `IDX_CTRL_FIRST; i <= `IDX_LAST_VALID; i++) begin
                ctrl_mem[i] <= `CTRL_RESET;
            end
        end else if (commit) begin
            ctrl_mem[frame_idx] <= in_shift_reg[7:0];
        end
    end

    // latched serial errors
    assign clear_all = clear_latched_errors | pin_clear_reg;

    latch_flag u_clk_flag (
        .clock    (clock),
        .rst      (sleep_reset),
        .set      (frame_end & ~len_ok),
        .clear    (clear_all),
        .flag_reg (clk_flag)
    );

    latch_flag u_par_flag (
        .clock    (clock),
        .rst      (sleep_reset),
        .set      (frame_end & len_ok & ~parity_ok),
        .clear    (clear_all),
        .flag_reg (par_flag)
    );

    latch_flag u_idx_flag (
        .clock    (clock),
        .rst      (sleep_reset),
        .set      (frame_end & len_ok & ~idx_ok),
        .clear    (clear_all),
        .flag_reg (idx_flag)
    );

    // status register contents
    assign ser_err = clk_flag | par_flag | idx_flag;
    assign ic_status_next = {1'h0, cond.regulator_fault, ser_err, cond.overcurrent,
                             cond.supply_ready, cond.overvoltage, cond.temperature,
                             cond.regulator_fault | ser_err | cond.overcurrent
                             | cond.overvoltage | cond.temperature};
    assign status_two_next = {1'h0, cond.status_two_hi, par_flag, clk_flag, idx_flag};

    always_ff @(posedge clock) begin
        if (sleep_reset) begin
            ic_status_reg  <= `STATUS_RESET;
            status_one_reg <= `STATUS_RESET;
            status_two_reg <= `STATUS_RESET;
        end else begin
            ic_status_reg  <= ic_status_next;
            status_one_reg <= cond.status_one;
            status_two_reg <= status_two_next;
        end
    end

    // pin outputs straight from flops
    always_ff @(posedge clock) begin
        if (sleep_reset) begin
            sdo_out       <= 1'h0;
            sdo_oe        <= 1'h0;
            error_out_low <= 1'h1;
        end else begin
            sdo_out       <= out_shift_reg[15];
            sdo_oe        <= in_frame_reg & ~cs_s;
            error_out_low <= ~ic_status_next[`IC_SUMMARY];
        end
    end

    // checks
    a_idle_output_hiz: assert property (@(posedge clock) disable iff (sys_rst)
        cs_s |=> !sdo_oe) else $error("output driven while deselected");

    a_status_msb_first: assert property (@(posedge clock) disable iff (sys_rst)
        (cs_fall && awake && !sleep_reset) ##1 !sleep_reset |=> sdo_out == $past(ic_status_reg[7], 2))
        else $error("status msb not first on output");

    a_write_old_value: assert property (@(posedge clock) disable iff (sleep_reset)
        read_phase && !cs_fall && !cs_rise |=> out_shift_reg[14:7] == $past(read_byte))
        else $error("register byte not loaded for answer");

    a_short_frame_flag: assert property (@(posedge clock) disable iff (sleep_reset)
        frame_end && !len_ok |=> clk_flag ##1 status_two_reg[`ST2_CLK_COUNT])
        else $error("frame length error not latched");

    a_parity_flag_set: assert property (@(posedge clock) disable iff (sleep_reset)
        frame_end && len_ok && !parity_ok |=> par_flag) else $error("parity error not latched");

    a_bad_index_flag: assert property (@(posedge clock) disable iff (sleep_reset)
        frame_end && len_ok && !idx_ok |=> idx_flag) else $error("bad index not latched");

    a_serial_summary: assert property (@(posedge clock) disable iff (sleep_reset)
        (|status_two_reg[2:0]) |-> ic_status_reg[`IC_SER_FLT] && ic_status_reg[`IC_SUMMARY])
        else $error("serial fault not summarised");

    a_supply_ready_copy: assert property (@(posedge clock) disable iff (sleep_reset)
        !$past(sleep_reset) |-> ic_status_reg[`IC_SUPPLY_READY] == $past(cond.supply_ready))
        else $error("supply ready bit wrong");

    a_sleep_clears_all: assert property (@(posedge clock) disable iff (sys_rst)
        sleep_state_reg == SLP_ASLEEP |=> status_two_reg == 8'h00 && !sdo_oe && !clk_flag)
        else $error("registers not reset in sleep");

    a_commit_lands: assert property (@(posedge clock) disable iff (sleep_reset)
        commit |=> ctrl_mem[$past(frame_idx)] == $past(in_shift_reg[7:0]))
        else $error("committed write not stored");

    c_write_commit: cover property (@(posedge clock) disable iff (sys_rst) commit);
    c_parity_error: cover property (@(posedge clock) disable iff (sys_rst)
        frame_end && len_ok && !parity_ok);
    c_sleep_entry: cover property (@(posedge clock) disable iff (sys_rst)
        sleep_state_reg == SLP_LOW ##1 sleep_state_reg == SLP_ASLEEP);
    c_pin_clear: cover property (@(posedge clock) disable iff (sys_rst) pin_clear_reg && ser_err);
endmodule
`default_nettype wire

// File: testbench/spi_ctrl_model.sv
// behavioural serial bus controller that faces the status port
`timescale 1ns/1ns
`default_nettype none
module spi_ctrl_model #(
    parameter int HALF = 10,
    parameter int GAP  = 60
) (
    // system
    input  wire logic clock,
    // serial pins
    output logic      sclk_pin,
    output logic      chip_select_low,
    output logic      sdi_pin,
    input  wire logic sdo_out,
    input  wire logic sdo_oe
);
    logic last_bit;
    wire  sdo_line;

    // released data line shows the inverse of its last driven level
    always @(posedge clock) begin
        if (sdo_oe) begin
            last_bit <= sdo_out;
        end
    end
    assign sdo_line = sdo_oe ? sdo_out : ~last_bit;

    // idle levels before any frame
    initial begin
        last_bit        = 1'b0;
        sclk_pin        = 1'b0;
        chip_select_low = 1'b1;
        sdi_pin         = 1'b0;
    end

    // one frame of nbits clocks, msb first, changes on rise and samples on fall
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] resp, output logic oe_seen);
        int k;
        resp    = 16'h0000;
        oe_seen = 1'b1;
        chip_select_low = 1'b0;
        repeat (HALF) @(negedge clock);
        for (k = 1; k <= nbits; k++) begin
            sclk_pin = 1'b1;
            sdi_pin  = (k <= 16) ? word[16-k] : ~sdi_pin;
            repeat (HALF) @(negedge clock);
            if (k <= 16) begin
                resp    = {resp[14:0], sdo_line};
                oe_seen = oe_seen & sdo_oe;
            end
            sclk_pin = 1'b0;
            repeat (HALF) @(negedge clock);
        end
        chip_select_low = 1'b1;
        sdi_pin         = ~sdi_pin;
        repeat (GAP) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// File: testbench/test_spi_secondary_status_port.sv
// self-checking bench of the serial status port against a reference model
`timescale 1ns/1ns
`default_nettype none
module test_spi_secondary_status_port
    import spi_sec_pkg::*;
;
    logic         clock;
    logic         sys_rst;
    logic         sleep_low_pin;
    logic         clear_latched_errors;
    driver_cond_s cond;
    wire          sclk_pin;
    wire          chip_select_low;
    wire          sdi_pin;
    wire          sdo_out;
    wire          sdo_oe;
    wire          error_out_low;
    int           errors;
    int           num_checks;
    integer       seed;
    logic [7:0]   ctrl [0:12];
    logic         fpar;
    logic         fclk;
    logic         fidx;
    logic [5:0]   idx_tab [0:9];

    // design and controller
    spi_secondary_status_port #(.RST_WINDOW(40)) i_spi_secondary_status_port (
        .clock(clock), .sys_rst(sys_rst), .sclk_pin(sclk_pin), .chip_select_low(chip_select_low),
        .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sleep_low_pin(sleep_low_pin),
        .error_out_low(error_out_low), .cond(cond), .clear_latched_errors(clear_latched_errors));
    spi_ctrl_model i_spi_ctrl_model (
        .clock(clock), .sclk_pin(sclk_pin), .chip_select_low(chip_select_low),
        .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe));

    // clock generator
    always #4 clock = ~clock;

    // compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // reference view of the status registers
    function automatic logic [7:0] ic_exp();
        logic s;
        s = fpar | fclk | fidx;
        return {1'b0, cond.regulator_fault, s, cond.overcurrent, cond.supply_ready, cond.overvoltage,
                cond.temperature, cond.regulator_fault | s | cond.overcurrent | cond.overvoltage | cond.temperature};
    endfunction

    function automatic logic [7:0] reg_exp(input logic [5:0] i);
        case (i)
            6'h00: return ic_exp();
            6'h01: return cond.status_one;
            6'h02: return {1'b0, cond.status_two_hi, fpar, fclk, fidx};
            default: return (i <= 6'h0C && i >= 6'h03) ? ctrl[i] : 8'h00;
        endcase
    endfunction

    function automatic logic [15:0] mk(input logic rw, input logic [5:0] ix, input logic [7:0] d, input logic flip);
        logic [15:0] w;
        w    = {rw, ix, 1'b0, d};
        w[8] = (^w) ^ flip;
        return w;
    endfunction

    // run one frame; eff 0 none, 1 write, 2 index flag, 3 parity flag, 4 count flag
    task automatic frame(input logic [15:0] w, input int n, input int eff, input logic full);
        logic [15:0] r;
        logic [15:0] exp;
        logic        oe;
        logic [7:0]  icv;
        exp = {ic_exp(), reg_exp(w[14:9])};
        i_spi_ctrl_model.xfer(w, n, r, oe);
        if (n == 16) begin
            chk("response", full ? r : {r[15:8], 8'h00}, full ? exp : {exp[15:8], 8'h00});
            chk("drive enable", {15'h0000, oe}, 16'h0001);
        end
        chk("idle enable", {15'h0000, sdo_oe}, 16'h0000);
        if (eff == 1 && !w[15] && ((w[14:9] >= 6'h03 && w[14:9] <= 6'h08) || w[14:9] == 6'h0C)) begin
            ctrl[w[14:9]] = w[7:0];
        end
        fidx = fidx | (eff == 2);
        fpar = fpar | (eff == 3);
        fclk = fclk | (eff == 4);
        icv = ic_exp();
        chk("fault pin", {15'h0000, error_out_low}, {15'h0000, ~icv[0]});
    endtask

    // watchdog
    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        sleep_low_pin = 1'b1;
        clear_latched_errors = 1'b0;
        cond = '0;
        errors = 0;
        num_checks = 0;
        seed = 64370;
        {fpar, fclk, fidx} = 3'b000;
        for (int i = 0; i < 13; i++) ctrl[i] = 8'h00;
        for (int i = 0; i < 9; i++) idx_tab[i] = 6'(i);
        idx_tab[9] = 6'h0C;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        repeat (5) @(negedge clock);
        // reset values of every listed register
        for (int i = 0; i < 10; i++) frame(mk(1'b1, idx_tab[i], 8'h00, 1'b0), 16, 0, 1'b1);
        // random reads and writes, back to back
        for (int i = 0; i < 16; i++) begin
            cond = driver_cond_s'(17'($random(seed)));
            frame(mk(1'(($random(seed))), idx_tab[$unsigned($random(seed)) % 10], 8'($random(seed)), 1'b0),
                  16, 1, 1'b1);
        end
        // error frames, each cleared by command or short sleep pulse
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: frame(mk(1'b1, 6'h0D + 6'($unsigned($random(seed)) % 51), 8'h00, 1'b0), 16, 2, 1'b0);
                1: frame(mk(1'b0, 6'h03, ~ctrl[3], 1'b1), 16, 3, 1'b1);
                2: frame(mk(1'b0, 6'h03, ~ctrl[3], 1'b0), 8, 4, 1'b1);
                default: frame(mk(1'b0, 6'h03, ~ctrl[3], 1'b0), 17, 4, 1'b1);
            endcase
            frame(mk(1'b1, 6'h02, 8'h00, 1'b0), 16, 0, 1'b1);
            frame(mk(1'b1, 6'h03, 8'h00, 1'b0), 16, 0, 1'b1);
            if (k % 2 == 0) begin
                clear_latched_errors = 1'b1;
                @(negedge clock);
                clear_latched_errors = 1'b0;
            end else begin
                sleep_low_pin = 1'b0;
                repeat (10) @(negedge clock);
                sleep_low_pin = 1'b1;
            end
            repeat (10) @(negedge clock);
            {fpar, fclk, fidx} = 3'b000;
            frame(mk(1'b1, 6'h02, 8'h00, 1'b0), 16, 0, 1'b1);
        end
        // long sleep returns the control bytes to defaults
        frame(mk(1'b0, 6'h04, 8'hA5, 1'b0), 16, 1, 1'b1);
        sleep_low_pin = 1'b0;
        repeat (80) @(negedge clock);
        sleep_low_pin = 1'b1;
        repeat (20) @(negedge clock);
        for (int i = 3; i < 13; i++) ctrl[i] = 8'h00;
        frame(mk(1'b1, 6'h04, 8'h00, 1'b0), 16, 0, 1'b1);
        frame(mk(1'b1, 6'h0C, 8'h00, 1'b0), 16, 0, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
